//--- hdl/gate_driver_enable_pwm_logic.sv
// Contract
// - Logic supply not ready forces full shutdown with gates low and a 40 us start-up.
// - Partial shutdown is a sleep mode with only housekeeping alive.
// - Trim settings load from fuses while asleep, before enabling.
// - Driver supply not ready with enable high keeps analog alive and gates low.
// - Gates follow PWM only with both supplies ready and enable high.
// - High gate follows PWM and low gate is its complement when enabled.
// - PWM held in the middle window past the hold-off pulls both gates low.
// - The PWM decode uses separate entry and exit levels with hysteresis.
// - Until power ready the temperature monitor output is driven strongly low.
// - PWM up to 1 MHz is followed without losing correspondence.
// - The short comparator is ignored for a blanking time of at most 50 ns.
// - Leaving tri-state the gates follow the new PWM level at once.
`timescale 1ns/1ps
`default_nettype none
`include "gate_drv_consts.svh"

module gate_driver_enable_pwm_logic #(
    parameter int unsigned FULL_START_CYC = `FULL_START_CYC,
    parameter int unsigned PART_START_CYC = `PART_START_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        nrst,
    // Wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    // Pins and comparators
    input  wire logic        enable_pin,
    input  wire logic        logic_supply_ok,
    input  wire logic        driver_supply_ok,
    input  wire logic        pwm_above_high_exit,
    input  wire logic        pwm_below_low_exit,
    input  wire logic        pwm_above_entry_fall,
    input  wire logic        pwm_below_entry_rise,
    input  wire logic        high_fet_short_detect,
    input  wire logic [7:0]  fuse_trim,
    output logic             high_gate_cmd,
    output logic             low_gate_cmd,
    output logic             temp_monitor_pull_low,
    output logic             sleep_mode,
    output logic             analog_alive,
    output logic             short_fault,
    output logic [7:0]       trim_out
);

    // ---------------------------------------------------------------
    // Reset release and pin synchronisers
    // ---------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            rst_sync_q <= 2'b00;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    localparam int NSYNC = 8;
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] s1_q;
    logic [NSYNC-1:0] s2_q;
    logic [NSYNC-1:0] s3_q;
    logic [NSYNC-1:0] pin_q;
    logic [NSYNC-1:0] pin_d;

    assign pin_raw = {high_fet_short_detect, pwm_below_entry_rise, pwm_above_entry_fall,
                      pwm_below_low_exit, pwm_above_high_exit, driver_supply_ok,
                      logic_supply_ok, enable_pin};

    // A change counts once stages two and three agree
    always_comb
    begin
        for (int i = 0; i < NSYNC; i++)
            pin_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : pin_q[i];
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            pin_q <= '0;
        end
        else
        begin
            s1_q  <= pin_raw;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            pin_q <= pin_d;
        end
    end

    logic en_s;
    logic vcc_s;
    logic driver_supply_s;
    logic short_s;
    assign en_s    = pin_q[0];
    assign vcc_s   = pin_q[1];
    assign driver_supply_s  = pin_q[2];
    assign short_s = pin_q[7];

    // ---------------------------------------------------------------
    // PWM decoder
    // ---------------------------------------------------------------
    pwm_dec_if pdi ();
    assign pdi.above_high_exit  = pin_q[3];
    assign pdi.below_low_exit   = pin_q[4];
    assign pdi.above_entry_fall = pin_q[5];
    assign pdi.below_entry_rise = pin_q[6];

    pwm_decoder u_dec (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .dec      (pdi.dec)
    );

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    logic       soft_en_q;
    logic       soft_en_d;
    logic       clr_short_d;
    logic       ack_q;
    logic       ack_d;
    logic       err_q;
    logic       err_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic       req;

    // ---------------------------------------------------------------
    // Power state machine
    // ---------------------------------------------------------------
    gate_drv_pkg::drv_state_e st_q;
    gate_drv_pkg::drv_state_e st_d;
    logic [15:0] start_cnt_q;
    logic [15:0] start_cnt_d;
    logic        ready_q;
    logic        ready_d;
    logic        from_full_q;
    logic        from_full_d;
    logic [3:0]  fuse_cnt_q;
    logic [3:0]  fuse_cnt_d;
    logic [7:0]  trim_q;
    logic [7:0]  trim_d;
    logic        en_eff;

    function automatic logic [15:0] cyc16(input int unsigned v);
        cyc16 = v[15:0];
    endfunction

    // Open or low enable pin and software enable both gate the driver
    assign en_eff = en_s & soft_en_q;

    always_comb
    begin
        st_d        = st_q;
        start_cnt_d = start_cnt_q;
        ready_d     = ready_q;
        from_full_d = from_full_q;
        fuse_cnt_d  = fuse_cnt_q;
        trim_d      = trim_q;
        if (!vcc_s)
        begin
            st_d        = gate_drv_pkg::ST_SHUTDOWN;
            ready_d     = 1'b0;
            from_full_d = 1'b1;
            start_cnt_d = '0;
            fuse_cnt_d  = '0;
        end
        else
        begin
            case (st_q)
                gate_drv_pkg::ST_SHUTDOWN:
                    st_d = gate_drv_pkg::ST_SLEEP;
                gate_drv_pkg::ST_SLEEP:
                begin
                    if (fuse_cnt_q != 4'(`FUSE_LOAD_CYC))
                    begin
                        fuse_cnt_d = fuse_cnt_q + 4'h1;
                        trim_d     = fuse_trim;
                    end
                    else if (en_eff)
                    begin
                        st_d        = gate_drv_pkg::ST_TRISTATE;
                        start_cnt_d = '0;
                    end
                end
                default:
                begin
                    if (!ready_q)
                    begin
                        if (start_cnt_q + 16'h0001 >= (from_full_q ? cyc16(FULL_START_CYC)
                                                                 : cyc16(PART_START_CYC)))
                        begin
                            ready_d     = 1'b1;
                            from_full_d = 1'b0;
                        end
                        else
                            start_cnt_d = start_cnt_q + 16'h0001;
                    end
                    if (!en_eff)
                    begin
                        st_d    = gate_drv_pkg::ST_SLEEP;
                        ready_d = 1'b0;
                    end
                    else if (!driver_supply_s || !ready_d)
                        st_d = gate_drv_pkg::ST_TRISTATE;
                    else
                        st_d = gate_drv_pkg::ST_ENABLED;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q        <= gate_drv_pkg::ST_SHUTDOWN;
            start_cnt_q <= '0;
            ready_q     <= 1'b0;
            from_full_q <= 1'b1;
            fuse_cnt_q  <= '0;
            trim_q      <= `TRIM_RESET_VAL;
        end
        else
        begin
            st_q        <= st_d;
            start_cnt_q <= start_cnt_d;
            ready_q     <= ready_d;
            from_full_q <= from_full_d;
            fuse_cnt_q  <= fuse_cnt_d;
            trim_q      <= trim_d;
        end
    end

    // ---------------------------------------------------------------
    // Gate commands, hold-off and short blanking
    // ---------------------------------------------------------------
    logic [7:0] hold_cnt_q;
    logic [7:0] hold_cnt_d;
    logic       hs_q;
    logic       hs_d;
    logic       ls_q;
    logic       ls_d;
    logic [7:0] blank_cnt_q;
    logic [7:0] blank_cnt_d;
    logic       short_q;
    logic       short_d;

    always_comb
    begin
        hold_cnt_d  = hold_cnt_q;
        hs_d        = 1'b0;
        ls_d        = 1'b0;
        blank_cnt_d = '0;
        short_d     = short_q;
        if (st_q == gate_drv_pkg::ST_ENABLED)
        begin
            case (pdi.level)
                gate_drv_pkg::PWM_HIGH:
                begin
                    hold_cnt_d = '0;
                    hs_d       = 1'b1;
                end
                gate_drv_pkg::PWM_LOW:
                begin
                    hold_cnt_d = '0;
                    ls_d       = 1'b1;
                end
                default:
                begin
                    if (hold_cnt_q < 8'(`HOLDOFF_CYC))
                    begin
                        hold_cnt_d = hold_cnt_q + 8'h01;
                        hs_d       = hs_q;
                        ls_d       = ls_q;
                    end
                end
            endcase
        end
        else
            hold_cnt_d = 8'(`HOLDOFF_CYC);
        if (short_s && hs_q)
        begin
            if (blank_cnt_q < 8'(`BLANK_CYC))
                blank_cnt_d = blank_cnt_q + 8'h01;
            else
            begin
                blank_cnt_d = blank_cnt_q;
                short_d     = 1'b1;
            end
        end
        // Detection wins over a clear in the same cycle
        else if (clr_short_d || !en_eff || !vcc_s)
            short_d = 1'b0;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hold_cnt_q  <= 8'(`HOLDOFF_CYC);
            hs_q        <= 1'b0;
            ls_q        <= 1'b0;
            blank_cnt_q <= '0;
            short_q     <= 1'b0;
        end
        else
        begin
            hold_cnt_q  <= hold_cnt_d;
            hs_q        <= hs_d;
            ls_q        <= ls_d;
            blank_cnt_q <= blank_cnt_d;
            short_q     <= short_d;
        end
    end

    assign high_gate_cmd = hs_q;
    assign low_gate_cmd  = ls_q;
    assign temp_monitor_pull_low = !ready_q;
    assign sleep_mode   = (st_q == gate_drv_pkg::ST_SLEEP);
    assign analog_alive = (st_q == gate_drv_pkg::ST_TRISTATE)
                          || (st_q == gate_drv_pkg::ST_ENABLED);
    assign short_fault  = short_q;
    assign trim_out     = trim_q;

    // ---------------------------------------------------------------
    // Wishbone slave: one wait state, ack dropped after one cycle
    // ---------------------------------------------------------------
    assign req = wb_cyc_i && wb_stb_i && !ack_q && !err_q;

    always_comb
    begin
        soft_en_d   = soft_en_q;
        clr_short_d = 1'b0;
        ack_d       = 1'b0;
        err_d       = 1'b0;
        rdata_d     = rdata_q;
        if (req)
        begin
            if (wb_adr_i == `REG_CTRL_ADDR)
            begin
                ack_d   = 1'b1;
                rdata_d = {30'h0000_0000, 1'b0, soft_en_q};
                if (wb_we_i && wb_sel_i[0])
                begin
                    soft_en_d   = wb_dat_i[`CTRL_SOFT_EN_BIT];
                    clr_short_d = wb_dat_i[`CTRL_CLR_SHORT_BIT];
                end
            end
            else if (wb_adr_i == `REG_STATUS_ADDR)
            begin
                ack_d   = 1'b1;
                rdata_d = {24'h00_0000, short_q, ready_q, pdi.level, st_q, hs_q, ls_q};
            end
            else if (wb_adr_i == `REG_TRIM_ADDR)
            begin
                ack_d   = 1'b1;
                rdata_d = {24'h00_0000, trim_q};
            end
            else
            begin
                err_d   = 1'b1;
                rdata_d = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            soft_en_q <= 1'(`CTRL_RESET_VAL >> `CTRL_SOFT_EN_BIT);
            ack_q     <= 1'b0;
            err_q     <= 1'b0;
            rdata_q   <= 32'h0000_0000;
        end
        else
        begin
            soft_en_q <= soft_en_d;
            ack_q     <= ack_d;
            err_q     <= err_d;
            rdata_q   <= rdata_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_err_o = err_q;
    assign wb_dat_o = rdata_q;

endmodule

`default_nettype wire

//--- hdl/gate_drv_consts.svh
`ifndef GATE_DRV_CONSTS_SVH
`define GATE_DRV_CONSTS_SVH

// ---------------------------------------------------------------
// Register map (byte addresses, one word each)
// ---------------------------------------------------------------
`define REG_CTRL_ADDR      8'h00
`define REG_STATUS_ADDR    8'h04
`define REG_TRIM_ADDR      8'h08

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define CTRL_SOFT_EN_BIT   0
`define CTRL_CLR_SHORT_BIT 1
`define CTRL_RESET_VAL     32'h0000_0001
`define TRIM_RESET_VAL     8'h00

// ---------------------------------------------------------------
// Timing in ns and cycle counts at 200 MHz (5 ns period)
// ---------------------------------------------------------------
`define CLK_PERIOD_NS      5
`define FULL_START_NS      40000
`define PART_START_NS      10000
`define HOLDOFF_NS         100
`define BLANK_MAX_NS       50
// Least times round up
`define FULL_START_CYC     ((`FULL_START_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PART_START_CYC     ((`PART_START_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLDOFF_CYC        ((`HOLDOFF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Longest time rounds down
`define BLANK_CYC          (`BLANK_MAX_NS / `CLK_PERIOD_NS)
// Trim fuse read takes a few cycles
`define FUSE_LOAD_CYC      8

`endif

//--- hdl/gate_drv_pkg.sv
package gate_drv_pkg;

    // Gray along shutdown -> sleep -> tristate -> enabled
    typedef enum logic [1:0] {
        ST_SHUTDOWN = 2'b00,
        ST_SLEEP    = 2'b01,
        ST_TRISTATE = 2'b11,
        ST_ENABLED  = 2'b10
    } drv_state_e;

    // Decoded PWM level
    typedef enum logic [1:0] {
        PWM_LOW  = 2'b00,
        PWM_MID  = 2'b01,
        PWM_HIGH = 2'b11
    } pwm_level_e;

endpackage

//--- hdl/pwm_dec_if.sv
`timescale 1ns/1ps
`default_nettype none

interface pwm_dec_if;
    logic                     above_high_exit;
    logic                     below_low_exit;
    logic                     above_entry_fall;
    logic                     below_entry_rise;
    gate_drv_pkg::pwm_level_e level;

    modport dec (input above_high_exit, below_low_exit, above_entry_fall, below_entry_rise,
                 output level);
    modport top (output above_high_exit, below_low_exit, above_entry_fall, below_entry_rise,
                 input level);
endinterface

`default_nettype wire

//--- hdl/pwm_decoder.sv
`timescale 1ns/1ps
`default_nettype none

module pwm_decoder (
    input  wire logic core_clk,
    input  wire logic rst_n,
    pwm_dec_if.dec    dec
);

    gate_drv_pkg::pwm_level_e level_q;
    gate_drv_pkg::pwm_level_e level_d;

    // ---------------------------------------------------------------
    // Hysteretic three-level decode
    // ---------------------------------------------------------------
    // separate entry and exit
    always_comb
    begin
        level_d = level_q;
        case (level_q)
            gate_drv_pkg::PWM_HIGH:
            begin
                // Leave high only once below the falling entry level
                if (dec.below_low_exit)
                    level_d = gate_drv_pkg::PWM_LOW;
                else if (!dec.above_entry_fall)
                    level_d = gate_drv_pkg::PWM_MID;
            end
            gate_drv_pkg::PWM_LOW:
            begin
                if (dec.above_high_exit)
                    level_d = gate_drv_pkg::PWM_HIGH;
                else if (!dec.below_entry_rise)
                    level_d = gate_drv_pkg::PWM_MID;
            end
            default:
            begin
                if (dec.above_high_exit)
                    level_d = gate_drv_pkg::PWM_HIGH;
                else if (dec.below_low_exit)
                    level_d = gate_drv_pkg::PWM_LOW;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            level_q <= gate_drv_pkg::PWM_MID;
        else
            level_q <= level_d;
    end

    assign dec.level = level_q;

endmodule

`default_nettype wire

//--- verif/pwm_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

module pwm_ctrl_model (
    input  wire logic [2:0] pwm_pos,
    output logic            above_high_exit,
    output logic            below_low_exit,
    output logic            above_entry_fall,
    output logic            below_entry_rise
);
    // ordered trip levels
    // Position climbs past low exit, rise entry, fall entry, high exit
    assign below_low_exit   = (pwm_pos == 3'h0);
    assign below_entry_rise = (pwm_pos <= 3'h1);
    assign above_entry_fall = (pwm_pos >= 3'h3);
    assign above_high_exit  = (pwm_pos >= 3'h4);
endmodule

`default_nettype wire

//--- verif/drv_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module drv_monitor (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic enable_pin,
    input wire logic logic_supply_ok,
    input wire logic driver_supply_ok,
    input wire logic pwm_above_high_exit,
    input wire logic pwm_below_low_exit,
    input wire logic pwm_above_entry_fall,
    input wire logic pwm_below_entry_rise,
    input wire logic high_fet_short_detect,
    input wire logic high_gate_cmd,
    input wire logic low_gate_cmd,
    input wire logic temp_monitor_pull_low,
    input wire logic short_fault
);
    default clocking mon_cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    logic       run_ok;
    logic       mid_raw;
    logic       off;
    logic [7:0] mid_q;
    logic [7:0] mid_d;
    logic [7:0] run_q;
    logic [7:0] run_d;
    logic [7:0] hit_q;
    logic [7:0] hit_d;

    function automatic logic [7:0] step(input logic inc, input logic [7:0] c);
        return inc ? c + {7'h00, c != 8'hFF} : 8'h00;
    endfunction

    assign run_ok  = enable_pin && logic_supply_ok && driver_supply_ok && !temp_monitor_pull_low;
    assign mid_raw = !(pwm_above_high_exit || pwm_below_low_exit || pwm_above_entry_fall
                       || pwm_below_entry_rise);
    assign off     = !high_gate_cmd && !low_gate_cmd;

    always_comb
    begin
        mid_d = step(mid_raw, mid_q);
        run_d = step(high_fet_short_detect, run_q);
        hit_d = step(high_fet_short_detect && high_gate_cmd, hit_q);
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mid_q <= 8'h00;
            run_q <= 8'h00;
            hit_q <= 8'h00;
        end
        else
        begin
            mid_q <= mid_d;
            run_q <= run_d;
            hit_q <= hit_d;
        end
    end

    sequence drive_high_s;
        (pwm_above_high_exit && run_ok)[*8];
    endsequence
    sequence drive_low_s;
        (pwm_below_low_exit && run_ok)[*8];
    endsequence

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    gates_excl_a: assert property (!(high_gate_cmd && low_gate_cmd))
        else $error("both gate commands high");
    cold_off_a: assert property ((!logic_supply_ok)[*8] |-> off)
        else $error("gates on without logic supply");
    en_off_a: assert property ((!enable_pin)[*8] |-> off)
        else $error("gates on with enable low");
    drv_off_a: assert property ((!driver_supply_ok)[*8] |-> off)
        else $error("gates on without driver supply");
    not_ready_a: assert property (temp_monitor_pull_low[*2] |-> off)
        else $error("gates on before power ready");
    pwm_high_a: assert property (drive_high_s |=> high_gate_cmd && !low_gate_cmd)
        else $error("high level not followed");
    pwm_low_a: assert property (drive_low_s |=> low_gate_cmd && !high_gate_cmd)
        else $error("low level not followed");
    hold_off_a: assert property (mid_q >= 8'h1E |-> off)
        else $error("gates on after long middle level");
    short_blank_a: assert property ($rose(short_fault) |-> run_q >= 8'h0A)
        else $error("short flagged inside blanking");
    short_catch_a: assert property (hit_q >= 8'h14 |-> short_fault)
        else $error("held short not flagged");
endmodule

bind gate_driver_enable_pwm_logic drv_monitor drv_monitor_inst (
    .core_clk, .nrst, .enable_pin, .logic_supply_ok, .driver_supply_ok,
    .pwm_above_high_exit, .pwm_below_low_exit, .pwm_above_entry_fall, .pwm_below_entry_rise,
    .high_fet_short_detect, .high_gate_cmd, .low_gate_cmd, .temp_monitor_pull_low, .short_fault
);

`default_nettype wire

//--- verif/gate_driver_enable_pwm_logic_bench.sv
`timescale 1ns/1ps
`default_nettype none

module gate_driver_enable_pwm_logic_bench;
    localparam int FULL = 40;
    localparam int PART = 10;
    logic        core_clk, nrst, wb_cyc, wb_stb, wb_we, wb_ack, wb_err;
    logic [7:0]  wb_adr, trim_o;
    logic [31:0] wb_dat_w, wb_dat_r;
    logic        en, lso, dso, ah, bl, af, br, shd, hs, ls, pl, slp, alive, sf;
    logic [2:0]  pos;
    int          err_count, samples_checked;

    gate_driver_enable_pwm_logic #(.FULL_START_CYC(FULL), .PART_START_CYC(PART))
    gate_driver_enable_pwm_logic_inst (
        .core_clk(core_clk), .nrst(nrst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_w),
        .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack), .wb_err_o(wb_err), .enable_pin(en),
        .logic_supply_ok(lso), .driver_supply_ok(dso), .pwm_above_high_exit(ah),
        .pwm_below_low_exit(bl), .pwm_above_entry_fall(af), .pwm_below_entry_rise(br),
        .high_fet_short_detect(shd), .fuse_trim(8'hA5), .high_gate_cmd(hs),
        .low_gate_cmd(ls), .temp_monitor_pull_low(pl), .sleep_mode(slp),
        .analog_alive(alive), .short_fault(sf), .trim_out(trim_o));

    pwm_ctrl_model pwm_ctrl_model_inst (.pwm_pos(pos), .above_high_exit(ah),
        .below_low_exit(bl), .above_entry_fall(af), .below_entry_rise(br));

    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic gates(input logic [1:0] e);
        chk({30'h0, hs, ls}, {30'h0, e});
    endtask

    // Classic cycle: hold request until ack or err is sampled
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] m, input logic [31:0] e, input logic e_err);
        @(posedge core_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_dat_w <= d;
        // Only the watchdog ends a wait for the answer
        do
        begin
            @(posedge core_clk);
        end while (wb_ack !== 1'b1 && wb_err !== 1'b1);
        chk({31'h0, wb_err}, {31'h0, e_err});
        if (!w)
            chk(wb_dat_r & m, e);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask

    task automatic ready_in(input int lo, input int hi);
        int n;
        n = 0;
        while (pl !== 1'b0 && n < 500)
        begin
            @(posedge core_clk);
            n++;
        end
        chk({31'h0, n >= lo && n <= hi}, 32'h1);
    endtask

    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        tick(20000);
        err_count++;
        wrap_up();
    end

    initial
    begin
        err_count = 0;
        samples_checked = 0;
        {nrst, wb_cyc, wb_stb, wb_we, en, lso, dso, shd} = 8'h00;
        wb_adr = 8'h00;
        wb_dat_w = 32'h0;
        pos = 3'h0;
        tick(16);
        nrst <= 1'b1;
        tick(4);
        gates(2'b00);
        chk({31'h0, pl}, 32'h1);
        bus(1'b0, 8'h04, 32'h0, 32'h0C, 32'h00, 1'b0);
        bus(1'b0, 8'h00, 32'h0, 32'h03, 32'h01, 1'b0);
        bus(1'b0, 8'h0C, 32'h0, 32'h00, 32'h00, 1'b1);
        lso <= 1'b1;
        tick(20);
        chk({31'h0, slp}, 32'h1);
        chk({24'h0, trim_o}, 32'hA5);
        bus(1'b0, 8'h04, 32'h0, 32'h0C, 32'h04, 1'b0);
        pos <= 3'h4;
        en <= 1'b1;
        ready_in(FULL, FULL + 12);
        chk({31'h0, alive}, 32'h1);
        gates(2'b00);
        dso <= 1'b1;
        tick(12);
        gates(2'b10);
        bus(1'b0, 8'h04, 32'h0, 32'h03, 32'h02, 1'b0);
        pos <= 3'h0;
        tick(12);
        gates(2'b01);
        // Same comparator input decodes by history
        pos <= 3'h1;
        tick(10);
        bus(1'b0, 8'h04, 32'h0, 32'h30, 32'h00, 1'b0);
        pos <= 3'h2;
        tick(10);
        bus(1'b0, 8'h04, 32'h0, 32'h30, 32'h10, 1'b0);
        pos <= 3'h1;
        tick(10);
        bus(1'b0, 8'h04, 32'h0, 32'h30, 32'h10, 1'b0);
        for (int i = 0; i < 2; i++)
        begin
            pos <= 3'h4;
            tick(12);
            pos <= 3'h2;
            tick(12);
            gates(2'b10);
            tick(20);
            gates(2'b00);
            pos <= i[0] ? 3'h4 : 3'h0;
            tick(10);
            gates(i[0] ? 2'b10 : 2'b01);
        end
        for (int k = 0; k < 8; k++)
        begin
            pos <= k[0] ? 3'h0 : 3'h4;
            tick(90);
            gates(k[0] ? 2'b01 : 2'b10);
            tick(10);
        end
        pos <= 3'h4;
        tick(12);
        shd <= 1'b1;
        tick(6);
        shd <= 1'b0;
        tick(20);
        chk({31'h0, sf}, 32'h0);
        shd <= 1'b1;
        tick(30);
        chk({31'h0, sf}, 32'h1);
        bus(1'b0, 8'h04, 32'h0, 32'h80, 32'h80, 1'b0);
        shd <= 1'b0;
        // Let the synchronised detect fall, else detection beats the clear
        tick(6);
        bus(1'b1, 8'h00, 32'h3, 32'h0, 32'h0, 1'b0);
        tick(2);
        chk({31'h0, sf}, 32'h0);
        pos <= 3'h0;
        tick(10);
        pos <= 3'h1;
        bus(1'b1, 8'h00, 32'h0, 32'h0, 32'h0, 1'b0);
        tick(10);
        gates(2'b00);
        bus(1'b1, 8'h00, 32'h1, 32'h0, 32'h0, 1'b0);
        tick(40);
        gates(2'b01);
        en <= 1'b0;
        tick(10);
        gates(2'b00);
        chk({31'h0, slp}, 32'h1);
        en <= 1'b1;
        ready_in(PART, PART + 12);
        {lso, dso, en} <= 3'b000;
        tick(10);
        gates(2'b00);
        chk({31'h0, slp}, 32'h0);
        // enable and driver supply before logic supply
        pos <= 3'h4;
        en <= 1'b1;
        tick(10);
        dso <= 1'b1;
        tick(10);
        lso <= 1'b1;
        ready_in(FULL, FULL + 30);
        tick(12);
        gates(2'b10);
        wrap_up();
    end
endmodule

`default_nettype wire
